/* File: sewt_target.sv */
// Two-wire serial memory target: framing, addressing, page write, reads and programming timer.
`timescale 1ns/10ps
module sewt_target #(
	parameter int PROG_CYCLES = sewt_pkg::PROG_TIME_CYCLES
) (
	input  wire logic       clk,               // System clock, 50 MHz.
	input  wire logic       srst,              // Synchronous reset, active high.
	input  wire logic       scl,               // Serial clock from the controller, link clock.
	input  wire logic       sda_in,            // Level of the serial data wire.
	output logic            sda_out,           // Value driven on the data wire, always low.
	output logic            sda_oe,            // High while the target pulls the data wire low.
	input  wire logic [2:0] chip_select_straps, // Select straps, bit 2 first in the address.
	input  wire logic       write_guard,       // High inhibits programming.
	output logic            prog_busy          // High during the self-timed programming cycle.
);

	localparam int TMR_W = $clog2(PROG_CYCLES + 1);
	// Programming writes the buffered bytes marked valid in its first eight cycles.
	if (PROG_CYCLES < sewt_pkg::PAGE_BYTES) begin : g_chk
		$error("PROG_CYCLES must cover at least one page of writes");
	end

	// Link domain: capture the data bit on each rising serial clock and flag it by a toggle.
	logic link_bit_reg = 1'b0;
	logic link_tog_reg = 1'b0;

	always_ff @(posedge scl) begin
		link_bit_reg <= sda_in;
		link_tog_reg <= ~link_tog_reg;
	end

	// Synchronisers for the toggle, the wire levels and the static pins.
	logic [2:0]         tog_sync_reg;
	logic [2:0]         scl_sync_reg;
	logic [2:0]         sda_sync_reg;
	sewt_pkg::sewt_pins_t pin_s1_reg;
	sewt_pkg::sewt_pins_t pin_s2_reg;
	sewt_pkg::sewt_evt_t  ev;

	always_ff @(posedge clk) begin
		if (srst) begin
			tog_sync_reg <= '0;
			scl_sync_reg <= '0;
			sda_sync_reg <= 3'h7;
			pin_s1_reg   <= '0;
			pin_s2_reg   <= '0;
		end else begin
			tog_sync_reg <= {tog_sync_reg[1:0], link_tog_reg};
			scl_sync_reg <= {scl_sync_reg[1:0], scl};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			pin_s1_reg   <= '{straps: chip_select_straps, guard: write_guard};
			pin_s2_reg   <= pin_s1_reg;
		end
	end

	// Event decode; the captured bit is stable for a whole serial clock period after its toggle.
	always_comb begin
		ev.start   = scl_sync_reg[2] & scl_sync_reg[1] & sda_sync_reg[2] & ~sda_sync_reg[1];
		ev.stop    = scl_sync_reg[2] & scl_sync_reg[1] & ~sda_sync_reg[2] & sda_sync_reg[1];
		ev.bit_ev  = tog_sync_reg[2] ^ tog_sync_reg[1];
		ev.bit_val = link_bit_reg;
		ev.fall    = scl_sync_reg[2] & ~scl_sync_reg[1];
	end

	// Engine and programming state.
	sewt_pkg::sewt_state_t state_reg, state_next;
	logic [3:0]            bit_cnt_reg, bit_cnt_next;
	logic [7:0]            shift_reg, shift_next;
	logic                  rw_reg, rw_next;
	logic                  ack_pend_reg, ack_pend_next;
	logic                  oe_reg, oe_next;
	logic [7:0]            addr_reg, addr_next;
	logic [7:0]            page_buf_reg [sewt_pkg::PAGE_BYTES];
	logic [7:0]            page_buf_next [sewt_pkg::PAGE_BYTES];
	logic [7:0]            vmask_reg, vmask_next;
	logic                  busy_reg, busy_next;
	logic [TMR_W-1:0]      tmr_reg, tmr_next;
	logic       mem_we;
	logic       mem_re;
	logic [7:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [7:0] byte_in;
	logic [2:0] tx_idx;
	logic       byte_done;
	logic       dev_match;
	logic       rd_nack;

	// Address compare of a received device address word.
	function automatic logic addr_matches(input logic [7:0] word, input logic [2:0] straps);
		addr_matches = (word[7:sewt_pkg::DEV_TYPE_LSB] == sewt_pkg::DEV_TYPE) &&
			(word[sewt_pkg::SEL_MSB:sewt_pkg::SEL_LSB] == straps);
	endfunction

	// Next-state logic for framing, addressing, data transfer and programming.
	always_comb begin
		state_next    = state_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		rw_next       = rw_reg;
		ack_pend_next = ack_pend_reg;
		oe_next       = oe_reg;
		addr_next     = addr_reg;
		page_buf_next = page_buf_reg;
		vmask_next    = vmask_reg;
		busy_next     = busy_reg;
		tmr_next      = tmr_reg;
		mem_we        = 1'b0;
		mem_re        = 1'b0;
		mem_addr      = addr_reg;
		mem_wdata     = page_buf_reg[tmr_reg[2:0]];
		byte_in       = {shift_reg[6:0], ev.bit_val};
		tx_idx        = 3'h7 - bit_cnt_reg[2:0];
		byte_done     = 1'b0;
		dev_match     = addr_matches(byte_in, pin_s2_reg.straps) && !busy_reg;
		rd_nack       = 1'b0;

		if (busy_reg) begin
			if (tmr_reg < TMR_W'(sewt_pkg::PAGE_BYTES)) begin
				mem_addr = {addr_reg[7:sewt_pkg::PAGE_BITS], tmr_reg[2:0]};
				mem_we   = vmask_reg[tmr_reg[2:0]];
			end
			if (tmr_reg == TMR_W'(PROG_CYCLES - 1)) begin
				busy_next  = 1'b0;
				vmask_next = '0;
			end else begin
				tmr_next = tmr_reg + 1'b1;
			end
		end

		if (ev.start) begin
			state_next    = sewt_pkg::ST_DEV;
			bit_cnt_next  = '0;
			ack_pend_next = 1'b0;
			oe_next       = 1'b0;
			if (!busy_reg) begin
				vmask_next = '0;
			end
		end else if (ev.stop) begin
			state_next    = sewt_pkg::ST_IDLE;
			ack_pend_next = 1'b0;
			oe_next       = 1'b0;
			if (state_reg == sewt_pkg::ST_WDATA && vmask_reg != '0 && !busy_reg) begin
				if (pin_s2_reg.guard) begin
					vmask_next = '0;
				end else begin
					busy_next = 1'b1;
					tmr_next  = '0;
				end
			end
		end else begin
			if (ev.bit_ev && state_reg != sewt_pkg::ST_IDLE && state_reg != sewt_pkg::ST_SKIP) begin
				if (bit_cnt_reg != sewt_pkg::BIT_ACK) begin
					shift_next   = byte_in;
					bit_cnt_next = bit_cnt_reg + 1'b1;
					if (bit_cnt_reg == sewt_pkg::BIT_LAST) begin
						byte_done = 1'b1;
						case (state_reg)
							sewt_pkg::ST_DEV: begin
								if (dev_match) begin
									ack_pend_next = 1'b1;
									rw_next = byte_in[sewt_pkg::RW_POS];
									if (byte_in[sewt_pkg::RW_POS]) begin
										mem_re    = 1'b1;
										addr_next = addr_reg + 1'b1;
									end
								end else begin
									state_next = sewt_pkg::ST_SKIP;
								end
							end
							sewt_pkg::ST_WORD: begin
								addr_next     = byte_in;
								ack_pend_next = 1'b1;
							end
							sewt_pkg::ST_WDATA: begin
								page_buf_next[addr_reg[2:0]] = byte_in;
								vmask_next[addr_reg[2:0]]    = 1'b1;
								addr_next     = {addr_reg[7:sewt_pkg::PAGE_BITS], addr_reg[2:0] + 3'h1};
								ack_pend_next = 1'b1;
							end
							default: begin
							end
						endcase
					end
				end else begin
					bit_cnt_next = '0;
					case (state_reg)
						sewt_pkg::ST_DEV: begin
							state_next = rw_reg ? sewt_pkg::ST_RDATA : sewt_pkg::ST_WORD;
						end
						sewt_pkg::ST_WORD: begin
							state_next = sewt_pkg::ST_WDATA;
						end
						sewt_pkg::ST_RDATA: begin
							if (!ev.bit_val) begin
								mem_re    = 1'b1;
								addr_next = addr_reg + 1'b1;
							end else begin
								rd_nack    = 1'b1;
								state_next = sewt_pkg::ST_SKIP;
							end
						end
						default: begin
						end
					endcase
				end
			end
			if (ev.fall) begin
				if (ack_pend_reg) begin
					oe_next       = 1'b1;
					ack_pend_next = 1'b0;
				end else if (state_reg == sewt_pkg::ST_RDATA && bit_cnt_reg != sewt_pkg::BIT_ACK) begin
					oe_next = ~mem_rdata[tx_idx];
				end else begin
					oe_next = 1'b0;
				end
			end
		end
	end

	// Engine and programming registers.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg    <= sewt_pkg::ST_IDLE;
			bit_cnt_reg  <= '0;
			shift_reg    <= '0;
			rw_reg       <= 1'b0;
			ack_pend_reg <= 1'b0;
			oe_reg       <= 1'b0;
			addr_reg     <= sewt_pkg::ADDR_RESET;
			page_buf_reg <= '{default: '0};
			vmask_reg    <= '0;
			busy_reg     <= 1'b0;
			tmr_reg      <= '0;
		end else begin
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			rw_reg       <= rw_next;
			ack_pend_reg <= ack_pend_next;
			oe_reg       <= oe_next;
			addr_reg     <= addr_next;
			page_buf_reg <= page_buf_next;
			vmask_reg    <= vmask_next;
			busy_reg     <= busy_next;
			tmr_reg      <= tmr_next;
		end
	end

	sewt_mem #(
		.ADDR_W (sewt_pkg::ADDR_W),
		.DATA_W (sewt_pkg::DATA_W)
	) u_mem (
		.clk   (clk),
		.srst  (srst),
		.we    (mem_we),
		.re    (mem_re),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	assign sda_out   = 1'b0;
	assign sda_oe    = oe_reg;
	assign prog_busy = busy_reg;

	// Checks on the clock domain of the engine.
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	busy_silent_a: assert property (
		prog_busy |-> !sda_oe ##1 !sda_oe
	) else $error("target drove the data wire during programming");
	guard_block_a: assert property (
		(ev.stop && pin_s2_reg.guard && !prog_busy) |=> !prog_busy [*2]
	) else $error("programming started with write guard high");
	prog_time_a: assert property (
		prog_busy |-> tmr_reg <= TMR_W'(PROG_CYCLES - 1)
	) else $error("programming timer ran past its limit");
	prog_end_a: assert property (
		$fell(prog_busy) |-> $past(tmr_reg) == TMR_W'(PROG_CYCLES - 1)
	) else $error("programming ended at the wrong count");
	page_wrap_a: assert property (
		(byte_done && state_reg == sewt_pkg::ST_WDATA) |=>
			addr_reg[7:3] == $past(addr_reg[7:3]) && addr_reg[2:0] == $past(addr_reg[2:0]) + 3'h1
	) else $error("write address left its page");
	read_advance_a: assert property (
		(mem_re && !busy_reg) |=> addr_reg == $past(addr_reg) + 8'h01
	) else $error("read address did not advance by one");
	mismatch_skip_a: assert property (
		(byte_done && state_reg == sewt_pkg::ST_DEV && !dev_match) |=>
			state_reg == sewt_pkg::ST_SKIP && !ack_pend_reg
	) else $error("mismatched address was not dropped");
	start_frame_a: assert property (
		ev.start |=> state_reg == sewt_pkg::ST_DEV && bit_cnt_reg == 4'h0 && !sda_oe
	) else $error("start did not open a new command");
	stop_idle_a: assert property (
		ev.stop |=> state_reg == sewt_pkg::ST_IDLE && !sda_oe
	) else $error("stop did not return to standby");
	nack_release_a: assert property (
		rd_nack |=> (state_reg == sewt_pkg::ST_SKIP && !sda_oe) [*6]
	) else $error("data wire held after controller nack");
	edge_only_a: assert property (
		$changed(sda_oe) |-> $past(ev.fall) || $past(ev.start) || $past(ev.stop)
	) else $error("data output changed away from a falling clock");
	ack_ninth_a: assert property (
		(byte_done && state_reg == sewt_pkg::ST_WORD) |=> ack_pend_reg ##1 (ack_pend_reg || sda_oe)
	) else $error("received word was not acknowledged");

	prog_run_c: cover property ($rose(prog_busy));
	read_byte_c: cover property (mem_re && state_reg == sewt_pkg::ST_RDATA);
	poll_nack_c: cover property (byte_done && state_reg == sewt_pkg::ST_DEV && busy_reg);
	page_wrap_c: cover property (byte_done && state_reg == sewt_pkg::ST_WDATA && addr_reg[2:0] == 3'h7);

endmodule // sewt_target

/* File: sewt_pkg.sv */
// Shared constants and types of the two-wire serial memory target.
package sewt_pkg;

	// Array shape: byte wide words, one byte address, pages of eight bytes.
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 8;
	localparam int PAGE_BITS  = 3;
	localparam int PAGE_BYTES = 8;

	// Fixed upper nibble of the device address word and field positions in it.
	localparam logic [3:0] DEV_TYPE     = 4'hA;
	localparam int         DEV_TYPE_LSB = 4;
	localparam int         SEL_MSB      = 3;
	localparam int         SEL_LSB      = 1;
	localparam int         RW_POS       = 0;

	// Bit counter values: last data bit of a byte and the ninth (acknowledge) bit.
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	// Address counter value after reset (power-up).
	localparam logic [7:0] ADDR_RESET = 8'h00;

	// Self-timed programming: longest time, rounded down to whole clock cycles.
	localparam int CLK_FREQ_KHZ     = 50000;
	localparam int PROG_TIME_MS     = 5;
	localparam int PROG_TIME_CYCLES = PROG_TIME_MS * CLK_FREQ_KHZ;

	// Engine states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WORD,
		ST_WDATA,
		ST_RDATA,
		ST_SKIP
	} sewt_state_t;

	// Bus events as seen in the system clock domain.
	typedef struct packed {
		logic start;
		logic stop;
		logic bit_ev;
		logic bit_val;
		logic fall;
	} sewt_evt_t;

	// Strap and guard pins after synchronisation.
	typedef struct packed {
		logic [2:0] straps;
		logic       guard;
	} sewt_pins_t;

endpackage

/* File: sewt_mem.sv */
// Byte array of the target with a registered read port.
`timescale 1ns/10ps
module sewt_mem #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	input  wire logic              clk,   // System clock.
	input  wire logic              srst,  // Synchronous reset, clears read data only.
	input  wire logic              we,    // Write strobe.
	input  wire logic              re,    // Read strobe.
	input  wire logic [ADDR_W-1:0] addr,  // Word address.
	input  wire logic [DATA_W-1:0] wdata, // Write data.
	output logic      [DATA_W-1:0] rdata  // Read data, one cycle after re.
);

	logic [DATA_W-1:0] mem_reg [2**ADDR_W];
	logic [DATA_W-1:0] rdata_reg;

	// The array keeps its contents over reset, as a non-volatile store would.
	always_ff @(posedge clk) begin
		if (we) begin
			mem_reg[addr] <= wdata;
		end
	end

	// Read data are held until the next read strobe.
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= '0;
		end else if (re) begin
			rdata_reg <= mem_reg[addr];
		end
	end

	assign rdata = rdata_reg;

endmodule // sewt_mem

/* File: sewt_ctrl_model.sv */
// Two-wire bus controller model that drives the serial clock and its side of the data wire.
`timescale 1ns/10ps
module sewt_ctrl_model (
	output logic      scl,    // Serial clock, stands high between frames.
	output logic      sda_oe, // High while the controller pulls the data wire low.
	input  wire logic sda     // Resolved level of the data wire.
);
	int slow_ns = 0; // Extra low time that makes the controller slow.

	// The bus is idle with both lines released.
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// data steady
	// Data changes only while the clock is low and is sampled as the clock rises.
	task automatic bit_xfer(input logic v, output logic s);
		#(20 + slow_ns) sda_oe = ~v;
		#80 scl = 1'b1;
		s = sda;
		#60 scl = 1'b0;
	endtask

	// start framing
	// Data falls while the clock is high; also serves as a repeated start.
	task automatic start();
		#20 sda_oe = 1'b0;
		#80 scl = 1'b1;
		#60 sda_oe = 1'b1;
		#60 scl = 1'b0;
	endtask

	// stop framing
	// Data rises while the clock is high; the clock then stands high.
	task automatic stop();
		#20 sda_oe = 1'b1;
		#80 scl = 1'b1;
		#60 sda_oe = 1'b0;
		#60;
	endtask

	// byte out
	// Bytes go out most significant bit first; the ninth bit is released for the answer.
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask

	// read ending
	// Eight bits are taken from the target, then low asks for more and high ends the read.
	task automatic read_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, s);
			d[i] = s;
		end
		bit_xfer(~more, s);
	endtask

	// poll then read
	// Polls with a write address until answered or 40 tries, loads the word address, then turns round.
	task automatic open_read(input logic [7:0] dev_w, input logic [7:0] word, output int tries, output logic ack);
		ack = 1'b0;
		tries = 0;
		while (!ack && tries < 40) begin
			tries++;
			start();
			send_byte(dev_w, ack);
		end
		if (ack) send_byte(word, ack);
		start();
		send_byte(dev_w | 8'h01, ack);
	endtask
endmodule // sewt_ctrl_model

/* File: sewt_target_bench.sv */
// Self-checking bench of the two-wire serial memory target with a controller model.
`timescale 1ns/10ps
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("ERROR %s expected %h seen %h", name, exp, got); end end
module sewt_target_bench;
	localparam int PROG = 256;
	logic       clk         = 1'b0;
	logic       srst        = 1'b1;
	logic       guard       = 1'b0;
	logic [2:0] straps      = 3'h0;
	logic       scl;
	logic       ctrl_oe;
	logic       sda_out;
	logic       sda_oe;
	logic       prog_busy;
	wire        sda         = ~(ctrl_oe | sda_oe);
	int         fails       = 0;
	int         checks_done = 0;
	int         busy_cnt    = 0;
	int         busy_mark   = 0;
	integer     seed        = 82216;
	logic [7:0] mirror [256];
	logic [7:0] bases [4];

	sewt_target #(.PROG_CYCLES(PROG)) u_sewt_target (.clk(clk), .srst(srst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(straps), .write_guard(guard),
		.prog_busy(prog_busy));
	sewt_ctrl_model u_sewt_ctrl_model (.scl(scl), .sda_oe(ctrl_oe), .sda(sda));

	// The system clock toggles every half period.
	always #10 clk = ~clk;

	// Busy cycles are counted to measure the programming time.
	always @(posedge clk) if (prog_busy === 1'b1) busy_cnt++;

	function automatic logic [7:0] page_addr(input logic [7:0] base, input int k);
		return {base[7:3], base[2:0] + 3'(k)};
	endfunction

	function automatic logic [7:0] dev_word(input logic rd);
		return {sewt_pkg::DEV_TYPE, straps, rd};
	endfunction

	// Writes n random bytes from base, mirroring them unless the guard is up.
	task automatic write_frame(input logic [7:0] base, input int n);
		logic       ack;
		logic [7:0] d;
		u_sewt_ctrl_model.start();
		u_sewt_ctrl_model.send_byte(dev_word(1'b0), ack);
		`CHK("write address ack", 1'b1, ack)
		u_sewt_ctrl_model.send_byte(base, ack);
		`CHK("word address ack", 1'b1, ack)
		for (int k = 0; k < n; k++) begin
			d = 8'($random(seed));
			u_sewt_ctrl_model.send_byte(d, ack);
			`CHK("data ack", 1'b1, ack)
			if (guard !== 1'b1) mirror[page_addr(base, k)] = d;
		end
		busy_mark = busy_cnt;
		u_sewt_ctrl_model.stop();
	endtask

	// Polls, reads n bytes from base and checks refusals and the programming time.
	task automatic read_frame(input logic [7:0] base, input int n, input logic polled, input int cnt);
		int         tries;
		logic       ack;
		logic [7:0] d;
		u_sewt_ctrl_model.open_read(dev_word(1'b0), base, tries, ack);
		`CHK("read address ack", 1'b1, ack)
		`CHK("polls refused while busy", polled, tries > 1)
		`CHK("programming cycles", cnt, busy_cnt - busy_mark)
		for (int k = 0; k < n; k++) begin
			u_sewt_ctrl_model.read_byte(k < n - 1, d);
			`CHK("read data", mirror[8'(base + k)], d)
		end
		u_sewt_ctrl_model.bit_xfer(1'b1, ack);
		`CHK("released after nack", 1'b1, ack)
		u_sewt_ctrl_model.stop();
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A hung run is cut short and counted as a mismatch.
	initial begin
		#1500000;
		fails++;
		end_sim();
	end

	// Main sequence: reset, refused addresses, page writes, reads, guard and wrap.
	initial begin
		logic       ack;
		logic [7:0] d;
		repeat (6) @(posedge clk);
		#1 srst = 1'b0;
		straps = 3'($random(seed));
		`CHK("busy in reset", 1'b0, prog_busy)
		repeat (4) @(posedge clk);
		// The link then runs out of phase with the system clock edges.
		#7;
		for (int k = 0; k < 8; k++) begin
			u_sewt_ctrl_model.start();
			u_sewt_ctrl_model.send_byte(k == 0 ? {4'h5, straps, 1'b0} : {4'hA, straps ^ 3'(k), 1'b0}, ack);
			`CHK("foreign address ack", 1'b0, ack)
			u_sewt_ctrl_model.stop();
		end
		bases = '{8'h00, 8'h08, 8'hF8, 8'($random(seed)) & 8'hF8};
		for (int i = 0; i < 4; i++) begin
			write_frame(bases[i] | 8'(3'($random(seed))), 8);
			read_frame(bases[i], 8, 1'b1, PROG);
		end
		write_frame(8'h05, 1);
		read_frame(8'h04, 3, 1'b1, PROG);
		u_sewt_ctrl_model.slow_ns = 300;
		read_frame(8'hFE, 4, 1'b0, PROG);
		u_sewt_ctrl_model.slow_ns = 0;
		u_sewt_ctrl_model.start();
		u_sewt_ctrl_model.send_byte(dev_word(1'b1), ack);
		`CHK("current read ack", 1'b1, ack)
		u_sewt_ctrl_model.read_byte(1'b0, d);
		`CHK("current address read", mirror[8'h02], d)
		u_sewt_ctrl_model.stop();
		@(posedge clk);
		#1 guard = 1'b1;
		write_frame(8'h0B, 8);
		read_frame(8'h08, 8, 1'b0, 0);
		`CHK("open drain value", 1'b0, sda_out)
		end_sim();
	end
endmodule // sewt_target_bench
